// File: common/sgp_pkg.sv
package sgp_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_BUSCTL_DIR = 32'h8007_FC60;
	localparam logic [31:0] ADDR_BUSCTL_ASSIGN = 32'h8007_FC64;
	localparam logic [31:0] ADDR_BUSCTL_VALUE = 32'h8007_FC68;
	localparam logic [31:0] ADDR_OUTPORT_ASSIGN = 32'h8007_FC84;
	localparam logic [31:0] ADDR_OUTPORT_VALUE = 32'h8007_FC88;
	localparam logic [31:0] ADDR_QUAD_DIR = 32'h8007_FC98;
	localparam logic [31:0] ADDR_QUAD_ASSIGN = 32'h8007_FC9C;
	localparam logic [31:0] ADDR_QUAD_VALUE = 32'h8007_FCA0;
	localparam logic [31:0] ADDR_MAP_LO = 32'h8007_FC60;
	localparam logic [31:0] ADDR_MAP_HI = 32'h8007_FCFF;

	// implemented bits per register, msb is pin 0 of the first port
	localparam logic [31:0] BUSCTL_DIR_MASK = 32'h1F00_0000;
	localparam logic [31:0] BUSCTL_ASSIGN_MASK = 32'h3F00_0000;
	localparam logic [31:0] BUSCTL_VALUE_MASK = 32'h1F00_0000;
	localparam logic [31:0] OUTPORT_MASK = 32'hFFFF_0000;
	localparam logic [31:0] QUAD_MASK = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;

	// pin groups set at reset; QI_MASK, QJ_MASK, QK_LO_MASK, QKL_HI_MASK and OB_HI_MASK steered by reset configuration bits
	localparam logic [31:0] QI_MASK = 32'hFF00_0000;
	localparam logic [31:0] QJ0_MASK = 32'h0080_0000;
	localparam logic [31:0] QJ_MASK = 32'h007F_0000;
	localparam logic [31:0] QK_LO_MASK = 32'h0000_C000;
	localparam logic [31:0] QKL_HI_MASK = 32'h0000_3F3F;
	localparam logic [31:0] QL_LO_MASK = 32'h0000_00C0;
	localparam logic [31:0] OA_MASK = 32'hFF00_0000;
	localparam logic [31:0] OB_LO_MASK = 32'h00F0_0000;
	localparam logic [31:0] OB_HI_MASK = 32'h000F_0000;

	// reset configuration word bits, numbered from the msb
	localparam int CFG_MSB = 31;
	localparam int CFG_SEL_QJ = 14;
	localparam int CFG_SEL_QK_LO = 15;
	localparam int CFG_SEL_QKL_HI = 16;
	localparam int CFG_SEL_QI = 17;
	localparam int CFG_SEL_BUSCTL = 18;
	localparam int CFG_SEL_PRU = 25;
	localparam int CFG_SEL_OB_HI = 26;
	localparam logic CFG_PRU_DEFAULT = 1'b0;

	// apb
	localparam int PROT_PRIV = 0;
	localparam int BYTE_W = 8;
	localparam int STRB_W = 4;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_EXT = 4'h4,
		ST_DONE = 4'h8
	} sgp_state_t;

	typedef struct packed
	{
		logic [31:0] func_sel;
		logic [31:0] out;
		logic [31:0] oe;
	} sgp_pins_t;

	typedef struct packed
	{
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] strb;
		logic write;
	} sgp_ext_t;

	function automatic logic cfg_on(input logic [31:0] cfg, input int n);
		return cfg[CFG_MSB - n];
	endfunction

endpackage

// File: src/sgp_sync.sv
`timescale 1ns/1ps
module sgp_sync
	import sgp_pkg::*;
#(
	parameter int WIDTH = 32
)
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// raw pins and filtered level
	input wire logic [WIDTH-1:0] pin_raw,
	output logic [WIDTH-1:0] pin_level
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	wire [WIDTH-1:0] agree = ~(s2 ^ s3);
	wire [WIDTH-1:0] next_level = (s3 & agree) | (pin_level & ~agree);

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			pin_level <= '0;
		end
		else
		begin
			s1 <= pin_raw;
			s2 <= s1;
			s3 <= s2;
			pin_level <= next_level;
		end
	end
endmodule

// File: src/sgp_ports.sv
// What this block does
// - bus interface pins become digital i/o when not used for bus role
// - i/o pins grouped in eight-bit ports, up to four ports sharing one set of registers
// - output-only ports have assign and data registers, no direction register
// - assign register picks primary function or i/o per pin
// - direction register sets each bidirectional pin input or output
// - data register drives output pins and reports input pins
// - pins not assigned to i/o ignore direction and data bits
// - replaceable port register accesses complete in three clocks
// - replacement mode blocks internal access and starts an external cycle
// - non-replaceable port register accesses complete in two clocks
// - config bit 25 selects replacement mode, default zero
// - bus-control port direction, assign, data at fc60, fc64, fc68
// - output pair assign at fc84, data at fc88
// - quad port direction fc98, assign fc9c, data fca0
// - data registers any privilege, direction and assign supervisor only
// - reset options latch from configuration word at reset release
// - data read gives pin level for inputs, latch otherwise
// - direction one is output, zero is input
// - inputs sampled synchronously through three stages, pin changes may lag four clocks
`timescale 1ns/1ps
module sgp_ports
	import sgp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// reset configuration word
	input wire logic [31:0] cfg_word,
	// apb slave
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [2:0] pprot,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external bus cycle in replacement mode
	output logic ext_req,
	output sgp_ext_t ext_cycle,
	input wire logic ext_ack,
	input wire logic [31:0] ext_rdata,
	// pins
	output sgp_pins_t busctl_pins,
	input wire logic [31:0] busctl_pin_in,
	output sgp_pins_t outport_pins,
	output sgp_pins_t quad_pins,
	input wire logic [31:0] quad_pin_in,
	// latched configuration
	output logic port_replacement_select
);
	sgp_state_t state;
	sgp_state_t next_state;
	logic cfg_done;
	logic ext_q;
	logic [31:0] busctl_port_direction;
	logic [31:0] busctl_port_assign;
	logic [31:0] busctl_port_value;
	logic [31:0] outport_pair_assign;
	logic [31:0] outport_pair_value;
	logic [31:0] quad_port_direction;
	logic [31:0] quad_port_assign;
	logic [31:0] quad_port_value;
	logic [31:0] busctl_sync;
	logic [31:0] quad_sync;

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wdata,
		input logic [3:0] strb, input logic [31:0] valid);
		logic [31:0] m;
		m = ZERO32;
		for (int i = 0; i < STRB_W; i++)
			m[i*BYTE_W +: BYTE_W] = {BYTE_W{strb[i]}};
		return ((old & ~m) | (wdata & m)) & valid;
	endfunction

	function automatic logic [31:0] sel_mask(input logic on, input logic [31:0] mask);
		return on ? mask : ZERO32;
	endfunction

	// input pins pass the three-stage filter
	// synchronous input sampling
	sgp_sync #(.WIDTH(32)) busctl_in_sync
	(
		.clk(clk),
		.resetn(resetn),
		.pin_raw(busctl_pin_in),
		.pin_level(busctl_sync)
	);

	sgp_sync #(.WIDTH(32)) quad_in_sync
	(
		.clk(clk),
		.resetn(resetn),
		.pin_raw(quad_pin_in),
		.pin_level(quad_sync)
	);

	// address decode
	// per-register hits for the bus-control, output pair and quad ports
	wire hit_mdir = paddr == ADDR_BUSCTL_DIR;
	wire hit_massign = paddr == ADDR_BUSCTL_ASSIGN;
	wire hit_mvalue = paddr == ADDR_BUSCTL_VALUE;
	wire hit_oassign = paddr == ADDR_OUTPORT_ASSIGN;
	wire hit_ovalue = paddr == ADDR_OUTPORT_VALUE;
	wire hit_qdir = paddr == ADDR_QUAD_DIR;
	wire hit_qassign = paddr == ADDR_QUAD_ASSIGN;
	wire hit_qvalue = paddr == ADDR_QUAD_VALUE;
	wire hit_busctl = hit_mdir | hit_massign | hit_mvalue;
	wire hit_repl = hit_oassign | hit_ovalue | hit_qdir | hit_qassign | hit_qvalue;
	wire in_block = (paddr >= ADDR_MAP_LO) && (paddr <= ADDR_MAP_HI);
	wire hit_reserved = in_block & ~hit_busctl & ~hit_repl;
	wire super_only = hit_mdir | hit_massign | hit_oassign | hit_qdir | hit_qassign;
	wire user_bad = super_only & ~pprot[PROT_PRIV];
	// outside the block is a bus error, reserved holes are not
	wire bad = user_bad | ~in_block;
	// replaceable ports go external in replacement mode
	wire go_ext = port_replacement_select & hit_repl;

	// configuration latched at the first edge after release
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cfg_done <= 1'b0;
			port_replacement_select <= CFG_PRU_DEFAULT;
		end
		else if (!cfg_done)
		begin
			cfg_done <= 1'b1;
			port_replacement_select <= cfg_on(cfg_word, CFG_SEL_PRU);
		end
	end

	wire [31:0] massign_dflt = sel_mask(cfg_on(cfg_word, CFG_SEL_BUSCTL), BUSCTL_ASSIGN_MASK);
	wire [31:0] oassign_dflt = OA_MASK | OB_LO_MASK | sel_mask(cfg_on(cfg_word, CFG_SEL_OB_HI), OB_HI_MASK);
	wire [31:0] qassign_dflt = QJ0_MASK | QL_LO_MASK
		| sel_mask(cfg_on(cfg_word, CFG_SEL_QI), QI_MASK)
		| sel_mask(cfg_on(cfg_word, CFG_SEL_QJ), QJ_MASK)
		| sel_mask(cfg_on(cfg_word, CFG_SEL_QK_LO), QK_LO_MASK)
		| sel_mask(cfg_on(cfg_word, CFG_SEL_QKL_HI), QKL_HI_MASK);

	// access sequencer
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_IDLE:
			begin
				if (psel && cfg_done)
				begin
					// others answer in the first access cycle
					if (go_ext)
						next_state = ST_EXT;
					else if (hit_repl)
						next_state = ST_WAIT;
					else
						next_state = ST_DONE;
				end
			end
			ST_WAIT: next_state = ST_DONE;
			ST_EXT:
			begin
				if (ext_ack)
					next_state = ST_DONE;
			end
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	wire st_done = state == ST_DONE;
	wire start = (state == ST_IDLE) && psel && cfg_done;
	assign pready = st_done;
	assign pslverr = st_done & ~ext_q & bad;
	assign ext_req = state == ST_EXT;
	// internal registers untouched on external cycles
	wire wr = st_done & psel & penable & pwrite & ~ext_q & ~bad;

	// pin level for discrete inputs, latch otherwise
	wire [31:0] m_in_mask = ~busctl_port_assign & ~busctl_port_direction & BUSCTL_VALUE_MASK;
	wire [31:0] q_in_mask = ~quad_port_assign & ~quad_port_direction & QUAD_MASK;
	wire [31:0] m_rd = (busctl_port_value & ~m_in_mask) | (busctl_sync & m_in_mask);
	wire [31:0] q_rd = (quad_port_value & ~q_in_mask) | (quad_sync & q_in_mask);
	// reserved and refused reads give zero
	wire [31:0] rd_value = (bad | pwrite) ? ZERO32
		: hit_mdir ? busctl_port_direction
		: hit_massign ? busctl_port_assign
		: hit_mvalue ? m_rd
		: hit_oassign ? outport_pair_assign
		: hit_ovalue ? outport_pair_value
		: hit_qdir ? quad_port_direction
		: hit_qassign ? quad_port_assign
		: hit_qvalue ? q_rd
		: ZERO32;
	wire load_rd = (state == ST_WAIT) || (start && !go_ext && !hit_repl);

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state <= ST_IDLE;
			ext_q <= 1'b0;
			prdata <= ZERO32;
			ext_cycle <= '0;
		end
		else
		begin
			state <= next_state;
			if (start)
			begin
				ext_q <= go_ext;
				ext_cycle <= '{addr: paddr, wdata: pwdata, strb: pstrb, write: pwrite};
			end
			if (load_rd)
				prdata <= rd_value;
			else if (ext_req && ext_ack)
				prdata <= pwrite ? ZERO32 : ext_rdata;
		end
	end

	// register file; data latches cleared at reset so pins start defined
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			busctl_port_direction <= ZERO32;
			busctl_port_assign <= ZERO32;
			busctl_port_value <= ZERO32;
			outport_pair_assign <= ZERO32;
			outport_pair_value <= ZERO32;
			quad_port_direction <= ZERO32;
			quad_port_assign <= ZERO32;
			quad_port_value <= ZERO32;
		end
		else if (!cfg_done)
		begin
			busctl_port_assign <= massign_dflt;
			outport_pair_assign <= oassign_dflt;
			quad_port_assign <= qassign_dflt;
		end
		else if (wr)
		begin
			if (hit_mdir)
				busctl_port_direction <= apply_strb(busctl_port_direction, pwdata, pstrb, BUSCTL_DIR_MASK);
			if (hit_massign)
				busctl_port_assign <= apply_strb(busctl_port_assign, pwdata, pstrb, BUSCTL_ASSIGN_MASK);
			if (hit_mvalue)
				busctl_port_value <= apply_strb(busctl_port_value, pwdata, pstrb, BUSCTL_VALUE_MASK);
			// output pair has no direction register
			if (hit_oassign)
				outport_pair_assign <= apply_strb(outport_pair_assign, pwdata, pstrb, OUTPORT_MASK);
			if (hit_ovalue)
				outport_pair_value <= apply_strb(outport_pair_value, pwdata, pstrb, OUTPORT_MASK);
			// eight-bit ports packed four to a word
			if (hit_qdir)
				quad_port_direction <= apply_strb(quad_port_direction, pwdata, pstrb, QUAD_MASK);
			if (hit_qassign)
				quad_port_assign <= apply_strb(quad_port_assign, pwdata, pstrb, QUAD_MASK);
			if (hit_qvalue)
				quad_port_value <= apply_strb(quad_port_value, pwdata, pstrb, QUAD_MASK);
		end
	end

	// primary-function pins get no drive from here
	wire [31:0] next_m_oe = busctl_port_direction & ~busctl_port_assign & BUSCTL_DIR_MASK;
	wire [31:0] next_o_oe = ~outport_pair_assign & OUTPORT_MASK;
	wire [31:0] next_q_oe = quad_port_direction & ~quad_port_assign & QUAD_MASK;

	// registered pin drive costs the one clock of lag the pins may show
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			busctl_pins <= '0;
			outport_pins <= '0;
			quad_pins <= '0;
		end
		else
		begin
			busctl_pins <= '{func_sel: busctl_port_assign, out: busctl_port_value & next_m_oe, oe: next_m_oe};
			outport_pins <= '{func_sel: outport_pair_assign, out: outport_pair_value & next_o_oe, oe: next_o_oe};
			quad_pins <= '{func_sel: quad_port_assign, out: quad_port_value & next_q_oe, oe: next_q_oe};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	two_clock_access_a: assert property (start && hit_busctl |-> ##1 pready)
		else $error("bus-control port access not two clocks");
	three_clock_access_a: assert property (start && hit_repl && !go_ext |-> ##1 !pready ##1 pready)
		else $error("replaceable port access not three clocks");
	// the far side sets the external length; only the hand-off edges are bounded
	ext_cycle_start_a: assert property (start && go_ext |=> ext_req && !pready && ext_cycle.addr == $past(paddr))
		else $error("replacement access did not go external");
	ext_hold_a: assert property (ext_req && !ext_ack |=> ext_req && !pready)
		else $error("external cycle ended before acknowledge");
	ext_end_a: assert property (ext_req && ext_ack |=> pready && !ext_req)
		else $error("external cycle not closed after acknowledge");
	cfg_assign_dflt_a: assert property ($rose(cfg_done) |-> quad_port_assign == $past(qassign_dflt))
		else $error("quad assign default not latched from config");
	quad_dir_drive_a: assert property (##1 quad_pins.oe == ($past(quad_port_direction) & ~$past(quad_port_assign)))
		else $error("quad pin drive does not follow direction");
	ext_no_write_a: assert property (ext_q && st_done |=> $stable(quad_port_value) && $stable(outport_pair_value))
		else $error("external cycle touched internal register");
	cfg_latch_pru_a: assert property ($rose(cfg_done) |-> port_replacement_select == $past(cfg_word[CFG_MSB - CFG_SEL_PRU]))
		else $error("replacement mode not latched from config");
	user_refused_a: assert property (st_done && user_bad && !ext_q |-> pslverr ##1 $stable(busctl_port_assign) && $stable(busctl_port_direction))
		else $error("user access to supervisor register not refused");
	reserved_zero_a: assert property (st_done && hit_reserved && !pwrite |-> prdata == ZERO32 && !pslverr)
		else $error("reserved read not zero");
	assign_no_drive_a: assert property (##1 (busctl_pins.oe & $past(busctl_port_assign)) == ZERO32)
		else $error("assigned pin driven by port logic");
	input_read_level_a: assert property (start && hit_mvalue && !pwrite |=> (prdata & $past(m_in_mask)) == ($past(busctl_sync) & $past(m_in_mask)))
		else $error("input pin read did not return level");
	out_follow_a: assert property ($past(wr) && $past(hit_qvalue) |=> (quad_pins.out & quad_pins.oe) == (quad_port_value & quad_pins.oe))
		else $error("output pin does not follow data latch");

	cover_busctl_write_c: cover property (start && hit_mdir && pwrite ##1 pready);
	cover_quad_read_c: cover property (start && hit_qvalue && !pwrite ##2 pready);
	cover_ext_c: cover property (ext_req ##[1:8] ext_ack);
	cover_back_to_back_c: cover property (st_done ##1 start);
	cover_refused_c: cover property (st_done && pslverr);
endmodule

// File: bench/sgp_far_end.sv
`timescale 1ns/1ps
module sgp_far_end
	import sgp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// external cycle
	input wire logic ext_req,
	input wire sgp_ext_t ext_cycle,
	input wire logic [3:0] delay,
	output logic ext_ack,
	output logic [31:0] ext_rdata,
	output logic [31:0] seen_addr,
	// pins
	input wire sgp_pins_t busctl_pins,
	input wire sgp_pins_t quad_pins,
	input wire logic [31:0] pattern,
	output logic [31:0] busctl_pin_in,
	output logic [31:0] quad_pin_in
);
	logic [3:0] cnt;
	// undriven pins show the far side level, not the last driven one
	assign busctl_pin_in = (busctl_pins.oe & busctl_pins.out) | (~busctl_pins.oe & pattern);
	assign quad_pin_in = (quad_pins.oe & quad_pins.out) | (~quad_pins.oe & pattern);
	always_ff @(posedge clk)
	begin
		if (!resetn || ext_ack)
		begin
			cnt <= 4'h0;
			ext_ack <= 1'b0;
			ext_rdata <= resetn ? ~ext_rdata : 32'h0000_0000;
		end
		else if (ext_req)
		begin
			cnt <= cnt + 4'h1;
			if (cnt == delay)
			begin
				ext_ack <= 1'b1;
				ext_rdata <= ~ext_cycle.addr;
				seen_addr <= ext_cycle.addr;
			end
		end
	end
endmodule

// File: bench/tb_sgp_ports.sv
`timescale 1ns/1ps
module tb_sgp_ports
	import sgp_pkg::*;
;
	localparam logic [31:0] PAT = 32'hA5C3_5A3C;
	localparam logic [31:0] CFG_N = 32'hFFFF_FFBF;
	localparam logic [31:0] CFG_R = 32'h0000_0040;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [31:0] cfg_word = CFG_N;
	logic [31:0] paddr = 32'h0000_0000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [2:0] pprot = 3'h1;
	logic [3:0] delay = 4'h1;
	logic [31:0] prdata, ext_rdata, seen_addr, busctl_pin_in, quad_pin_in, rd;
	logic pready, pslverr, ext_req, ext_ack, port_replacement_select, er;
	sgp_ext_t ext_cycle;
	sgp_pins_t busctl_pins, outport_pins, quad_pins;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int ncyc;
	sgp_ports i_sgp_ports (.clk(clk), .resetn(resetn), .cfg_word(cfg_word), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .pprot(pprot), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_req(ext_req), .ext_cycle(ext_cycle), .ext_ack(ext_ack),
		.ext_rdata(ext_rdata), .busctl_pins(busctl_pins), .busctl_pin_in(busctl_pin_in),
		.outport_pins(outport_pins), .quad_pins(quad_pins), .quad_pin_in(quad_pin_in),
		.port_replacement_select(port_replacement_select));
	sgp_far_end i_sgp_far_end (.clk(clk), .resetn(resetn), .ext_req(ext_req), .ext_cycle(ext_cycle),
		.delay(delay), .ext_ack(ext_ack), .ext_rdata(ext_rdata), .seen_addr(seen_addr),
		.busctl_pins(busctl_pins), .quad_pins(quad_pins), .pattern(PAT), .busctl_pin_in(busctl_pin_in),
		.quad_pin_in(quad_pin_in));
	always #10 clk = ~clk;
	// whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			results;
		end
	end
	task results;
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one apb transfer; ncyc counts setup through the ready cycle
	task apb(input logic [31:0] a, input logic [31:0] d, input logic w, input logic [2:0] p);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwdata <= d;
		pwrite <= w;
		pprot <= p;
		@(posedge clk);
		penable <= 1'b1;
		ncyc = 1;
		do
		begin
			@(posedge clk);
			ncyc++;
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rst(input logic [31:0] c);
		resetn <= 1'b0;
		cfg_word <= c;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		// later changes of the word must not leak in
		cfg_word <= ~c;
		// pin flops take the latched defaults one edge later
		repeat (2) @(posedge clk);
	endtask
	task t_reset;
		rst(CFG_N);
		chk("quad sel", 32'hFFFF_FFFF, quad_pins.func_sel);
		chk("out sel", 32'hFFFF_0000, outport_pins.func_sel);
		chk("bus sel", 32'h3F00_0000, busctl_pins.func_sel);
		chk("pru", 32'h0, {31'h0, port_replacement_select});
		apb(ADDR_QUAD_DIR, 32'h0, 1'b0, 3'h1);
		chk("quad dir", 32'h0, rd);
	endtask
	task t_timing;
		apb(ADDR_BUSCTL_VALUE, 32'h0, 1'b0, 3'h1);
		chk("bus len", 32'd2, ncyc);
		apb(ADDR_QUAD_VALUE, 32'h0, 1'b0, 3'h1);
		chk("quad len", 32'd3, ncyc);
		apb(ADDR_OUTPORT_VALUE, 32'h0, 1'b0, 3'h1);
		chk("out len", 32'd3, ncyc);
	endtask
	task t_quad;
		apb(ADDR_QUAD_ASSIGN, 32'h0, 1'b1, 3'h1);
		apb(ADDR_QUAD_DIR, 32'hFF00_0000, 1'b1, 3'h1);
		apb(ADDR_QUAD_VALUE, 32'h3C5A_9966, 1'b1, 3'h1);
		// input filter needs a few clocks to settle
		repeat (8) @(posedge clk);
		chk("quad oe", 32'hFF00_0000, quad_pins.oe);
		chk("quad out", 32'h3C00_0000, quad_pins.out);
		apb(ADDR_QUAD_VALUE, 32'h0, 1'b0, 3'h1);
		chk("quad rd", 32'h3CC3_5A3C, rd);
		apb(ADDR_QUAD_ASSIGN, 32'hFF00_0000, 1'b1, 3'h1);
		repeat (3) @(posedge clk);
		chk("quad sel", 32'hFF00_0000, quad_pins.func_sel);
		chk("quad oe", 32'h0, quad_pins.oe);
	endtask
	task t_busctl;
		apb(ADDR_BUSCTL_ASSIGN, 32'h0, 1'b1, 3'h1);
		apb(ADDR_BUSCTL_DIR, 32'hFFFF_FFFF, 1'b1, 3'h1);
		apb(ADDR_BUSCTL_VALUE, 32'hFFFF_FFFF, 1'b1, 3'h1);
		repeat (3) @(posedge clk);
		chk("bus oe", 32'h1F00_0000, busctl_pins.oe);
		chk("bus out", 32'h1F00_0000, busctl_pins.out);
		apb(ADDR_BUSCTL_DIR, 32'h0, 1'b1, 3'h1);
		repeat (8) @(posedge clk);
		apb(ADDR_BUSCTL_VALUE, 32'h0, 1'b0, 3'h1);
		chk("bus rd", 32'h0500_0000, rd);
		apb(ADDR_OUTPORT_ASSIGN, 32'h0, 1'b1, 3'h1);
		apb(ADDR_OUTPORT_VALUE, 32'h1234_5678, 1'b1, 3'h1);
		repeat (3) @(posedge clk);
		chk("out pins", 32'h1234_0000, outport_pins.out);
		chk("out oe", 32'hFFFF_0000, outport_pins.oe);
		apb(ADDR_OUTPORT_VALUE, 32'h0, 1'b0, 3'h1);
		chk("out rd", 32'h1234_0000, rd);
	endtask
	task t_priv;
		apb(ADDR_QUAD_DIR, 32'hFFFF_FFFF, 1'b1, 3'h0);
		chk("user err", 32'h1, {31'h0, er});
		apb(ADDR_QUAD_DIR, 32'h0, 1'b0, 3'h1);
		chk("quad dir", 32'hFF00_0000, rd);
		apb(ADDR_QUAD_VALUE, 32'h0, 1'b1, 3'h0);
		chk("user data", 32'h0, {31'h0, er});
		apb(ADDR_QUAD_VALUE, 32'h0, 1'b0, 3'h0);
		chk("user rd", 32'h00C3_5A3C, rd);
	endtask
	task t_reserved;
		apb(32'h8007_FC6C, 32'hFFFF_FFFF, 1'b1, 3'h1);
		chk("hole err", 32'h0, {31'h0, er});
		apb(32'h8007_FC6C, 32'h0, 1'b0, 3'h1);
		chk("hole rd", 32'h0, rd);
		apb(32'h8007_FD00, 32'h0, 1'b0, 3'h1);
		chk("out err", 32'h1, {31'h0, er});
	endtask
	task t_pru;
		rst(CFG_R);
		chk("pru", 32'h1, {31'h0, port_replacement_select});
		chk("quad sel", 32'h0080_00C0, quad_pins.func_sel);
		chk("out sel", 32'hFFF0_0000, outport_pins.func_sel);
		apb(ADDR_BUSCTL_ASSIGN, 32'h0, 1'b0, 3'h1);
		chk("bus rd", 32'h0, rd);
		chk("bus len", 32'd2, ncyc);
		delay <= 4'h5;
		apb(ADDR_QUAD_VALUE, 32'h0, 1'b0, 3'h1);
		chk("ext rd", ~ADDR_QUAD_VALUE, rd);
		chk("ext addr", ADDR_QUAD_VALUE, seen_addr);
		chk("ext slow", 32'h1, {31'h0, ncyc > 7});
		delay <= 4'h0;
		apb(ADDR_QUAD_DIR, 32'hFFFF_FFFF, 1'b1, 3'h1);
		apb(ADDR_QUAD_ASSIGN, 32'h0, 1'b1, 3'h1);
		repeat (3) @(posedge clk);
		chk("blocked", 32'h0080_00C0, quad_pins.func_sel);
		chk("ext addr", ADDR_QUAD_ASSIGN, seen_addr);
	endtask
	initial
	begin
		t_reset;
		t_timing;
		t_quad;
		t_busctl;
		t_priv;
		t_reserved;
		t_pru;
		results;
	end
endmodule
